// ### core/l2c_pkg.sv
// Overview of operation
// R1: Internal coherency RAM, 8K entries by 2 bits
// R2: Config 0x41 bit 4 enables coherency test mode
// R3: Test mode passes only code cycles to memory
// R4: Test mode redirects data cycles to coherency RAM
// R5: Entry address is host_addr[15:5]; [31:17] ignored
// R6: Test data write stores host_data[1:0]
// R7: Test data read captured into register 0x53
// R8: 0x41 fields: RAM type, size, tag width
// R9: 0x42 = 0x15 enables, forces miss, non-dirty
// R10: 0x42 = 0x00 disables; bit 0 enables normally
// R11: Sizes 256K/512K/1M; tags 11/10/8 bits; code gives 10 at 256K, 11 at 512K/1M, 8 when bit 0 is clear
// R12: 0x41 selects one or two bank cache RAM
// R13: 0x4e/0x4f enable shadow writes; zero closes
// R14: 0x4c/0x4d enable shadow reads
// R15: 0x50/0x51 mark shadow regions cacheable
// R16: Software opens, copies, closes, then enables caches
// R17: Test mode off: data cycles decode normally
// R18: Cache disabled: cycles bypass cache RAM
package l2c_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_TYPE_SIZE_TAG = 8'h41;
    localparam logic [7:0] OFS_L2_ENABLE     = 8'h42;
    localparam logic [7:0] OFS_L1_ENABLE     = 8'h43;
    localparam logic [7:0] OFS_SHD_RD_LO     = 8'h4c;
    localparam logic [7:0] OFS_SHD_RD_HI     = 8'h4d;
    localparam logic [7:0] OFS_SHD_WR_LO     = 8'h4e;
    localparam logic [7:0] OFS_SHD_WR_HI     = 8'h4f;
    localparam logic [7:0] OFS_SHD_CA_LO     = 8'h50;
    localparam logic [7:0] OFS_SHD_CA_HI     = 8'h51;
    localparam logic [7:0] OFS_COH_RD_DATA   = 8'h53;

    // ****************************************************************
    // Field positions and encodings
    // ****************************************************************
    localparam int BIT_TAG8       = 0;
    localparam int BIT_SIZE_LO    = 1;
    localparam int BIT_SIZE_HI    = 2;
    localparam int BIT_BANK2      = 3;
    localparam int BIT_TEST_MODE  = 4;
    localparam int BIT_TYPE_LO    = 6;
    localparam int BIT_TYPE_HI    = 7;
    localparam int BIT_L2_EN      = 0;
    localparam int BIT_FORCE_MISS = 2;
    localparam int BIT_NON_DIRTY  = 4;
    localparam logic [1:0] TYPE_PIPE_BURST = 2'h3;
    localparam logic [1:0] SIZE_256K       = 2'h1;
    localparam logic [1:0] SIZE_512K       = 2'h2;
    localparam logic [1:0] SIZE_1M         = 2'h3;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [3:0] TAG_W_SHORT     = 4'h8;
    localparam logic [3:0] TAG_W_MID       = 4'ha;
    localparam logic [3:0] TAG_W_LONG      = 4'hb;

    // ****************************************************************
    // Coherency RAM geometry and host address slice
    // ****************************************************************
    localparam int COH_ENTRIES  = 8192;
    localparam int COH_WIDTH    = 2;
    localparam int COH_ADDR_W   = 13;
    localparam int HA_ENTRY_LO  = 5;
    localparam int HA_ENTRY_HI  = 15;
    localparam int HA_WIDTH     = 32;
    localparam int HD_WIDTH     = 64;

    // Decoded cache configuration
    typedef struct packed {
        logic       l2_enable;
        logic       force_miss;
        logic       non_dirty;
        logic       pipe_burst;
        logic       two_bank;
        logic [1:0] size_sel;
        logic [3:0] tag_bits;
    } l2c_cfg_t;

    // Host cycle request
    typedef struct packed {
        logic                valid;
        logic                write;
        logic                code;
        logic [HA_WIDTH-1:0] addr;
        logic [HD_WIDTH-1:0] data;
    } l2c_host_t;

endpackage

// ### core/l2c_config.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module l2c_config
    import l2c_pkg::*;
#(
    // Coherency RAM depth, must match the entry address width
    parameter int COH_DEPTH = COH_ENTRIES
)
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [7:0]             reg_rdata,
    // Host memory cycle
    input  wire l2c_host_t              host_cycle,
    // Routing of the cycle
    output logic                        mem_cycle_valid,
    output logic                        cache_lookup_valid,
    output logic                        coh_test_access,
    // Decoded configuration
    output l2c_cfg_t                    cfg,
    output logic                        l1_enable,
    output logic      [15:0]            shadow_read_en,
    output logic      [15:0]            shadow_write_en,
    output logic      [15:0]            shadow_cacheable
);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [7:0] type_size_tag_reg;
    logic [7:0] l2_enable_reg;
    logic [7:0] l1_enable_reg;
    logic [7:0] shd_rd_lo_reg;
    logic [7:0] shd_rd_hi_reg;
    logic [7:0] shd_wr_lo_reg;
    logic [7:0] shd_wr_hi_reg;
    logic [7:0] shd_ca_lo_reg;
    logic [7:0] shd_ca_hi_reg;
    logic [7:0] coh_rd_data_reg;
    logic [7:0] rdata_reg;
    logic       test_mode;

    // Coherency state storage, one entry per cache line [R1]
    logic [COH_WIDTH-1:0] coh_ram [COH_DEPTH];
    logic                 coh_capture_reg;
    logic [COH_WIDTH-1:0] coh_word_reg;

    // Every entry index must land inside the array
    if (COH_DEPTH != (1 << COH_ADDR_W)) begin : g_depth_chk
        $error("coherency depth must match entry address width");
    end

    // Entry index from the host address; upper bits never matter
    function automatic logic [COH_ADDR_W-1:0] entry_of(
        input logic [HA_WIDTH-1:0] a);
        entry_of = {2'h0, a[HA_ENTRY_HI:HA_ENTRY_LO]}; // [R5]
    endfunction

    // Register writes; software owns all of them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            type_size_tag_reg <= RST_ZERO;
            l2_enable_reg     <= RST_ZERO;
            l1_enable_reg     <= RST_ZERO;
            shd_rd_lo_reg     <= RST_ZERO;
            shd_rd_hi_reg     <= RST_ZERO;
            shd_wr_lo_reg     <= RST_ZERO;
            shd_wr_hi_reg     <= RST_ZERO;
            shd_ca_lo_reg     <= RST_ZERO;
            shd_ca_hi_reg     <= RST_ZERO;
        end else if (reg_write) begin
            case (reg_addr)
                OFS_TYPE_SIZE_TAG: type_size_tag_reg <= reg_wdata; // [R2]
                OFS_L2_ENABLE:     l2_enable_reg <= reg_wdata; // [R9] [R10]
                OFS_L1_ENABLE:     l1_enable_reg <= reg_wdata;
                OFS_SHD_RD_LO:     shd_rd_lo_reg <= reg_wdata; // [R14]
                OFS_SHD_RD_HI:     shd_rd_hi_reg <= reg_wdata; // [R14]
                OFS_SHD_WR_LO:     shd_wr_lo_reg <= reg_wdata; // [R13]
                OFS_SHD_WR_HI:     shd_wr_hi_reg <= reg_wdata; // [R13]
                OFS_SHD_CA_LO:     shd_ca_lo_reg <= reg_wdata; // [R15]
                OFS_SHD_CA_HI:     shd_ca_hi_reg <= reg_wdata; // [R15]
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Decode of configuration fields
    // ****************************************************************
    assign test_mode = type_size_tag_reg[BIT_TEST_MODE]; // [R2]

    // Tag width from size bits and tag select [R8] [R11]
    always_comb begin
        cfg            = '0;
        cfg.l2_enable  = l2_enable_reg[BIT_L2_EN];              // [R10]
        cfg.force_miss = l2_enable_reg[BIT_FORCE_MISS];         // [R9]
        cfg.non_dirty  = l2_enable_reg[BIT_NON_DIRTY];          // [R9]
        cfg.pipe_burst = type_size_tag_reg[BIT_TYPE_HI:BIT_TYPE_LO]
                         == TYPE_PIPE_BURST;                    // [R8]
        cfg.size_sel   = type_size_tag_reg[BIT_SIZE_HI:BIT_SIZE_LO];
        // Larger sizes only work with the two-bank arrangement
        cfg.two_bank   = type_size_tag_reg[BIT_BANK2]
                         || cfg.size_sel == SIZE_512K
                         || cfg.size_sel == SIZE_1M;            // [R12]
        if (type_size_tag_reg[BIT_TAG8] == 1'b0)
            cfg.tag_bits = TAG_W_SHORT;                         // [R11]
        else if (cfg.size_sel == SIZE_256K)
            cfg.tag_bits = TAG_W_MID;
        else
            cfg.tag_bits = TAG_W_LONG;
    end

    assign l1_enable        = l1_enable_reg[BIT_L2_EN];
    assign shadow_read_en   = {shd_rd_hi_reg, shd_rd_lo_reg};   // [R14]
    assign shadow_write_en  = {shd_wr_hi_reg, shd_wr_lo_reg};   // [R13]
    // Cacheable only where the region is also readable
    assign shadow_cacheable = {shd_ca_hi_reg, shd_ca_lo_reg}
                              & shadow_read_en;                 // [R15]

    // ****************************************************************
    // Host cycle routing
    // ****************************************************************
    // Data cycles go to the RAM in test mode, code cycles pass on
    assign coh_test_access = host_cycle.valid && test_mode
                             && !host_cycle.code;               // [R4]
    assign mem_cycle_valid = host_cycle.valid            // [R3] [R17]
                             && (!test_mode || host_cycle.code);
    // Disabled cache leaves its RAMs untouched
    assign cache_lookup_valid = mem_cycle_valid
                                && cfg.l2_enable;               // [R18]

    // Test writes and reads of the coherency RAM
    always_ff @(posedge clk) begin
        if (coh_test_access && host_cycle.write)
            coh_ram[entry_of(host_cycle.addr)] <=
                host_cycle.data[COH_WIDTH-1:0];                 // [R6]
        coh_word_reg <= coh_ram[entry_of(host_cycle.addr)];
    end

    // Read data lands in the status register one cycle later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coh_capture_reg <= 1'b0;
            coh_rd_data_reg <= RST_ZERO;
        end else begin
            coh_capture_reg <= coh_test_access && !host_cycle.write;
            if (coh_capture_reg)
                coh_rd_data_reg <= {6'h00, coh_word_reg};       // [R7]
        end
    end

    // Read port, data valid one cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= RST_ZERO;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_TYPE_SIZE_TAG: rdata_reg <= type_size_tag_reg;
                OFS_L2_ENABLE:     rdata_reg <= l2_enable_reg;
                OFS_L1_ENABLE:     rdata_reg <= l1_enable_reg;
                OFS_SHD_RD_LO:     rdata_reg <= shd_rd_lo_reg;
                OFS_SHD_RD_HI:     rdata_reg <= shd_rd_hi_reg;
                OFS_SHD_WR_LO:     rdata_reg <= shd_wr_lo_reg;
                OFS_SHD_WR_HI:     rdata_reg <= shd_wr_hi_reg;
                OFS_SHD_CA_LO:     rdata_reg <= shd_ca_lo_reg;
                OFS_SHD_CA_HI:     rdata_reg <= shd_ca_hi_reg;
                OFS_COH_RD_DATA:   rdata_reg <= coh_rd_data_reg; // [R7]
                default:           rdata_reg <= RST_ZERO;
            endcase
        end else begin
            rdata_reg <= RST_ZERO;
        end
    end
    assign reg_rdata = rdata_reg;

endmodule // l2c_config

// ### dv/l2c_config_chk.sv
`timescale 1ns/1ns
module l2c_config_chk
    import l2c_pkg::*;
(
    // Clock, reset, register port
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    // Host cycle, routing, configuration
    input wire l2c_host_t   host_cycle,
    input wire logic        mem_cycle_valid,
    input wire logic        cache_lookup_valid,
    input wire logic        coh_test_access,
    input wire l2c_cfg_t    cfg,
    input wire logic        l1_enable,
    input wire logic [15:0] shadow_read_en,
    input wire logic [15:0] shadow_write_en,
    input wire logic [15:0] shadow_cacheable
);
    // ****************************************************************
    // Test mode shadow, rebuilt from writes since the bit is not a port
    // ****************************************************************
    logic test_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            test_reg <= 1'b0;
        else if (reg_write && reg_addr == OFS_TYPE_SIZE_TAG)
            test_reg <= reg_wdata[BIT_TEST_MODE];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_test_redirect: assert property (test_reg && host_cycle.valid &&
        !host_cycle.code |-> coh_test_access && !mem_cycle_valid)
        else $error("data cycle not redirected in test mode");
    chk_code_pass: assert property (host_cycle.valid && host_cycle.code
        |-> mem_cycle_valid && !coh_test_access)
        else $error("code cycle not passed to memory");
    chk_normal_decode: assert property (host_cycle.valid && !test_reg
        |-> mem_cycle_valid && !coh_test_access)
        else $error("cycle misrouted with test mode off");
    chk_lookup_gate: assert property (cache_lookup_valid
        |-> mem_cycle_valid && cfg.l2_enable)
        else $error("lookup while cache off");
    chk_l2_enable: assert property (reg_write
        && reg_addr == OFS_L2_ENABLE
        |=> cfg.l2_enable == $past(reg_wdata[0]))
        else $error("enable bit not applied");
    chk_tag_eight: assert property (reg_write && !reg_wdata[0] &&
        reg_addr == OFS_TYPE_SIZE_TAG |=> cfg.tag_bits == 4'h8)
        else $error("tag width not eight");
    chk_shadow_write: assert property (reg_write &&
        reg_addr == OFS_SHD_WR_LO
        |=> shadow_write_en[7:0] == $past(reg_wdata))
        else $error("shadow write enable not applied");
    chk_cache_and: assert property (
        (shadow_cacheable & ~shadow_read_en) == 16'h0000)
        else $error("cacheable outside readable region");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    cover property (host_cycle.valid && coh_test_access);
    cover property (reg_read && reg_addr == OFS_COH_RD_DATA);
    cover property (cache_lookup_valid);
endmodule // l2c_config_chk
bind l2c_config l2c_config_chk l2c_config_chk_inst (.clk, .resetn,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .host_cycle,
    .mem_cycle_valid, .cache_lookup_valid, .coh_test_access, .cfg,
    .l1_enable, .shadow_read_en, .shadow_write_en, .shadow_cacheable);

// ### dv/l2c_host_model.sv
`timescale 1ns/1ns
module l2c_host_model
    import l2c_pkg::*;
(
    // Clock and routing seen back
    input  wire logic clk,
    input  wire logic mem_cycle_valid,
    input  wire logic cache_lookup_valid,
    input  wire logic coh_test_access,
    // Host cycle driven
    output l2c_host_t host_cycle
);
    initial host_cycle = '0;
    // One cycle; routing sampled mid-cycle as {mem, lookup, test}
    task automatic op(input logic w, c, input logic [31:0] a,
                      input logic [63:0] d, output logic [2:0] r);
        @(posedge clk);
        host_cycle <= '{1'b1, w, c, a, d};
        @(negedge clk);
        r = {mem_cycle_valid, cache_lookup_valid, coh_test_access};
        @(posedge clk);
        host_cycle.valid <= 1'b0;
        host_cycle.addr <= ~a; // Idle bus must not hold old value
        host_cycle.data <= ~d;
    endtask
endmodule // l2c_host_model

// ### dv/l2c_config_tb.sv
`timescale 1ns/1ns
module l2c_config_tb
    import l2c_pkg::*;
;
    logic clk = 0, resetn = 0, reg_write = 0, reg_read = 0, l1_enable;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rv;
    logic [2:0] r;
    l2c_host_t host_cycle;
    l2c_cfg_t cfg;
    logic mem_cycle_valid, cache_lookup_valid, coh_test_access;
    logic [15:0] shadow_read_en, shadow_write_en, shadow_cacheable;
    int n_mismatch = 0, check_count = 0;
    logic [7:0] ofs [7] = '{8'h41, 8'h42, 8'h43, 8'h4c, 8'h4d, 8'h4e, 8'h4f};
    always #5 clk = ~clk;
    l2c_config l2c_config_inst (.clk, .resetn, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .host_cycle, .mem_cycle_valid,
        .cache_lookup_valid, .coh_test_access, .cfg, .l1_enable,
        .shadow_read_en, .shadow_write_en, .shadow_cacheable);
    l2c_host_model l2c_host_model_inst (.clk, .mem_cycle_valid,
        .cache_lookup_valid, .coh_test_access, .host_cycle);
    // ****************************************************************
    // Bus tasks and comparison
    // ****************************************************************
    task automatic chk(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // Write ends at negedge so decoded outputs have settled
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        rv = reg_rdata;
    endtask
    // Test read, one spare edge before fetching the captured entry
    task automatic tread(input logic [31:0] a, input logic [7:0] e);
        l2c_host_model_inst.op(1'b0, 1'b0, a, 64'h0, r);
        @(posedge clk);
        rd(OFS_COH_RD_DATA);
        chk("entry", rv, e);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk("reset", rv, 0);
            wr(ofs[i], 8'h21 + 8'(i) * 8'h11);
            rd(ofs[i]);
            chk("readback", rv, 8'h21 + 8'(i) * 8'h11);
        end
        chk("l1", l1_enable, 1);
        wr(8'h53, 8'hff);
        wr(8'h60, 8'hff);
        rd(8'h53);
        chk("read only", rv, 0);
        rd(8'h60);
        chk("unmapped", rv, 0);
        // Size, tag and bank decode over the three sizes
        wr(OFS_TYPE_SIZE_TAG, 8'hc2);
        chk("c2", {cfg.pipe_burst, cfg.two_bank, cfg.tag_bits}, 6'h28);
        wr(OFS_TYPE_SIZE_TAG, 8'hc3);
        chk("256k", {cfg.two_bank, cfg.tag_bits}, 5'h0a);
        wr(OFS_TYPE_SIZE_TAG, 8'hc5);
        chk("512k", {cfg.two_bank, cfg.tag_bits}, 5'h1b);
        wr(OFS_TYPE_SIZE_TAG, 8'hc6);
        chk("1m", {cfg.two_bank, cfg.tag_bits}, 5'h18);
        wr(OFS_L2_ENABLE, 8'h15);
        chk("l2c", {cfg.l2_enable, cfg.force_miss, cfg.non_dirty}, 7);
        // Init order: L2 cache off, shadow open, closed, readable, cached
        wr(OFS_L2_ENABLE, 8'h00);
        l2c_host_model_inst.op(1'b0, 1'b0, 32'h1000, 64'h0, r);
        chk("off", r, 3'b100);
        wr(OFS_SHD_WR_LO, 8'haa);
        wr(OFS_SHD_WR_HI, 8'h55);
        chk("swr", shadow_write_en, 16'h55aa);
        wr(OFS_SHD_WR_LO, 8'h00);
        wr(OFS_SHD_WR_HI, 8'h00);
        chk("swr0", shadow_write_en, 0);
        wr(OFS_SHD_RD_LO, 8'h0f);
        wr(OFS_SHD_RD_HI, 8'hf0);
        wr(OFS_SHD_CA_LO, 8'hff);
        wr(OFS_SHD_CA_HI, 8'hff);
        chk("srd", shadow_read_en, 16'hf00f);
        chk("sca", shadow_cacheable, 16'hf00f);
        wr(OFS_L2_ENABLE, 8'h01);
        l2c_host_model_inst.op(1'b1, 1'b0, 32'h1000, 64'h0, r);
        chk("on", r, 3'b110);
        // Coherency RAM test mode, high address bits set to be ignored
        wr(OFS_TYPE_SIZE_TAG, 8'hd2);
        l2c_host_model_inst.op(1'b1, 1'b1, 32'h2000, 64'h0, r);
        chk("code", {r[2], r[0]}, 2'b10);
        l2c_host_model_inst.op(1'b1, 1'b0, 32'hfffe0020, 64'hfd, r);
        chk("data", {r[2], r[0]}, 2'b01);
        l2c_host_model_inst.op(1'b1, 1'b0, 32'h0000ffe0, 64'h2, r);
        tread(32'h00000020, 8'h01);
        tread(32'hfffeffe0, 8'h02);
        complete_run();
    end
endmodule // l2c_config_tb
